/* design/flash_prot_pkg.sv */
// Package with register map, field positions, reset values and counts for flash protection.
package flash_prot_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_EBS = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    localparam logic [3:0] OFS_RAMC = 4'hc;

    // Flash control register field positions.
    localparam int CTRL_PGM = 0;
    localparam int CTRL_ERS = 1;
    localparam int CTRL_PVF = 2;
    localparam int CTRL_EVF = 3;
    localparam int CTRL_PSU = 4;
    localparam int CTRL_ESU = 5;
    localparam int CTRL_SWE = 6;

    // Flash status register field positions.
    localparam int STAT_PGM = 0;
    localparam int STAT_ERS = 1;
    localparam int STAT_PVF = 2;
    localparam int STAT_EVF = 3;
    localparam int STAT_HWP = 4;
    localparam int STAT_NMI = 5;
    localparam int STAT_ERR = 7;

    // RAM overlay control fields: select bit and area field.
    localparam int RAMC_SEL = 3;
    localparam int RAMC_AREA_LSB = 1;
    localparam int RAMC_AREA_MSB = 2;

    // Values after reset.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] EBS_RESET = 8'h00;
    localparam logic [7:0] RAMC_RESET = 8'h00;

    // Value returned by a flash read while programming or erasing.
    localparam logic [7:0] UNDEF_READ = 8'ha5;

    // Least number of low cycles on the external reset pin during operation.
    localparam int RESET_HOLD_CYCLES = 20;

    // Boot phase: NMI held off until the boot program branches into RAM.
    typedef enum logic [0:0] {
        PH_NORMAL = 1'b0,
        PH_BOOT = 1'b1
    } boot_phase_t;

endpackage

/* design/flash_protect.sv */
// Flash program and erase protection core with control registers and NMI masking.
//
// Contract
// - Write-enable pin low clears registers, protects.
// - Resets and standby initialise registers, protect.
// - Pin reset needs twenty low cycles.
// - Error during program/erase sets error flag.
// - Error keeps registers, aborts ongoing operation.
// - Error flag blocks program and erase entry.
// - Verify modes still work under error.
// - Only pin, watchdog, hardware standby clear error.
// - Registers writable in error; software standby clears.
// - Overlay select protects all blocks, verify allowed.
// - Block select gives per-block erase protection only.
// - All-zero block select protects every block.
// - Software protection blocks erase entry; only overlay select blocks program.
// - Write-enable pin low cancels RAM overlay.
// - Hardware protection makes every block unerasable.
// - Mask NMI while programming, erasing, early boot.
// - Mask NMI in error and emulated program/erase.
// - After boot branch, NMI accepted when idle.
// - Flash reads during program/erase return undefined.
// - Modes entered through control register bits.
// - No operation without pin high and enable bit.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module flash_protect
    import flash_prot_pkg::*;
#(
    parameter int NUM_BLOCKS = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic flash_write_enable_pin,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic sw_standby,
    input wire logic hw_standby,
    input wire logic error_detect,
    input wire logic boot_mode,
    input wire logic boot_branch_ram,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] flash_array_data,
    output logic [7:0] flash_rd_data,
    output logic program_mode,
    output logic erase_mode,
    output logic program_verify_mode,
    output logic erase_verify_mode,
    output logic [NUM_BLOCKS-1:0] erase_block_enable,
    output logic overlay_active,
    output logic nmi_mask,
    output logic device_reset
);
    // The block select shares one byte of the register port.
    if (NUM_BLOCKS < 1 || NUM_BLOCKS > 8) begin : g_bad_blocks
        $error("flash_protect: NUM_BLOCKS must be 1 to 8");
    end

    localparam logic [NUM_BLOCKS-1:0] BLK_ZERO = '0;

    reset_filter_if rf ();

    assign rf.ce = ce;
    assign rf.external_reset_pin_n = external_reset_pin_n;

    reset_pin_filter #(
        .HOLD(RESET_HOLD_CYCLES)
    ) u_filter (
        .clk_sys(clk_sys),
        .rst(rst),
        .rf(rf)
    );

    // Stored state.
    logic [7:0] flash_control_reg;
    logic [7:0] flash_control_next;
    logic [NUM_BLOCKS-1:0] erase_block_select_reg;
    logic [NUM_BLOCKS-1:0] erase_block_select_next;
    logic [7:0] ram_overlay_control_reg;
    logic [7:0] ram_overlay_control_next;
    logic flash_error_flag_reg;
    logic flash_error_flag_next;
    boot_phase_t boot_phase_reg;
    boot_phase_t boot_phase_next;

    // Output registers.
    logic [7:0] reg_rdata_reg;
    logic [7:0] reg_rdata_next;
    logic [7:0] flash_rd_data_reg;
    logic [7:0] flash_rd_data_next;
    logic program_mode_reg;
    logic erase_mode_reg;
    logic program_verify_mode_reg;
    logic erase_verify_mode_reg;
    logic [NUM_BLOCKS-1:0] erase_block_enable_reg;
    logic [NUM_BLOCKS-1:0] erase_block_enable_next;
    logic overlay_active_reg;
    logic nmi_mask_reg;
    logic nmi_mask_next;
    logic device_reset_reg;

    // Address decode of the register port.
    wire sel_ctrl = (reg_addr == OFS_CTRL);
    wire sel_ebs = (reg_addr == OFS_EBS);
    wire sel_stat = (reg_addr == OFS_STAT);
    wire sel_ramc = (reg_addr == OFS_RAMC);
    wire wr_ctrl = reg_wr & sel_ctrl;
    wire wr_ebs = reg_wr & sel_ebs;
    wire wr_ramc = reg_wr & sel_ramc;

    // Protection sources; a low write-enable pin is hardware protection.
    wire hw_protect = ~flash_write_enable_pin;
    wire any_reset = rf.pin_reset | watchdog_reset;
    wire init_regs = any_reset | sw_standby | hw_standby
                     | hw_protect;
    wire error_clear = any_reset | hw_standby;
    wire ram_select = ram_overlay_control_reg[RAMC_SEL];
    wire sw_enable_ok = flash_control_reg[CTRL_SWE] & flash_write_enable_pin;
    wire blocks_chosen = (erase_block_select_reg != BLK_ZERO);
    wire sw_protect = ram_select | ~blocks_chosen;

    // Mode entry: error or overlay refuse program and erase, not verify.
    wire pgm_go = sw_enable_ok & flash_control_reg[CTRL_PGM] & flash_control_reg[CTRL_PSU]
                  & ~flash_error_flag_reg & ~ram_select;
    wire erase_go = sw_enable_ok & flash_control_reg[CTRL_ERS] & flash_control_reg[CTRL_ESU]
                    & ~flash_error_flag_reg & ~sw_protect;
    wire pv_go = sw_enable_ok & flash_control_reg[CTRL_PVF];
    wire ev_go = sw_enable_ok & flash_control_reg[CTRL_EVF];
    wire busy = pgm_go | erase_go;

    // An error only counts while an operation is really running.
    wire error_set = error_detect & (program_mode_reg | erase_mode_reg);

    // Emulated program or erase: bits held while the overlay is selected.
    wire emu_hold = sw_enable_ok & ram_select
                    & (flash_control_reg[CTRL_PGM] | flash_control_reg[CTRL_ERS]);
    wire boot_hold = boot_mode & (boot_phase_reg == PH_BOOT);

    // Control register: cleared by protection sources, otherwise writable,
    // even under error so software can still walk into verify.
    assign flash_control_next = init_regs ? CTRL_RESET :
                                wr_ctrl ? reg_wdata : flash_control_reg;
    assign erase_block_select_next = init_regs ? EBS_RESET[NUM_BLOCKS-1:0] :
                                     wr_ebs ? reg_wdata[NUM_BLOCKS-1:0] :
                                     erase_block_select_reg;

    // The overlay is dropped when the pin goes low or on a reset.
    assign ram_overlay_control_next = (hw_protect | any_reset) ? RAMC_RESET :
                                      wr_ramc ? reg_wdata : ram_overlay_control_reg;

    // Error flag: a new error wins over a clear in the same cycle.
    assign flash_error_flag_next = error_set ? 1'b1 :
                                   error_clear ? 1'b0 : flash_error_flag_reg;

    // Boot phase: every reset reopens it, the branch into RAM closes it.
    assign boot_phase_next = any_reset ? PH_BOOT :
                             boot_branch_ram ? PH_NORMAL : boot_phase_reg;

    // Per-block enable: empty unless erase_go holds; unlike erase_mode it is not gated by an error in the same cycle.
    assign erase_block_enable_next = erase_go ? erase_block_select_reg : BLK_ZERO;

    assign nmi_mask_next = busy | flash_error_flag_reg
                           | emu_hold | boot_hold;

    // Flash data is meaningless while the array is being written.
    assign flash_rd_data_next = busy ? UNDEF_READ : flash_array_data;

    // Read mux; unmapped addresses and idle cycles read as zero.
    wire [7:0] stat_val = {flash_error_flag_reg, 1'b0, nmi_mask_reg, hw_protect,
                           erase_verify_mode_reg, program_verify_mode_reg,
                           erase_mode_reg, program_mode_reg};
    wire [7:0] ebs_val = 8'(erase_block_select_reg);
    assign reg_rdata_next = !reg_rd ? 8'h00 :
                            sel_ctrl ? flash_control_reg :
                            sel_ebs ? ebs_val :
                            sel_stat ? stat_val :
                            sel_ramc ? ram_overlay_control_reg : 8'h00;

    // Register state; reset acts regardless of the clock enable.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flash_control_reg <= CTRL_RESET;
            erase_block_select_reg <= EBS_RESET[NUM_BLOCKS-1:0];
            ram_overlay_control_reg <= RAMC_RESET;
            flash_error_flag_reg <= 1'b0;
            boot_phase_reg <= PH_BOOT;
        end else if (ce) begin
            flash_control_reg <= flash_control_next;
            erase_block_select_reg <= erase_block_select_next;
            ram_overlay_control_reg <= ram_overlay_control_next;
            flash_error_flag_reg <= flash_error_flag_next;
            boot_phase_reg <= boot_phase_next;
        end
    end

    // Registered outputs; program and erase modes fall the cycle after an error arises.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            program_mode_reg <= 1'b0;
            erase_mode_reg <= 1'b0;
            program_verify_mode_reg <= 1'b0;
            erase_verify_mode_reg <= 1'b0;
            erase_block_enable_reg <= BLK_ZERO;
            overlay_active_reg <= 1'b0;
            nmi_mask_reg <= 1'b1;
            device_reset_reg <= 1'b1;
            reg_rdata_reg <= 8'h00;
            flash_rd_data_reg <= 8'h00;
        end else if (ce) begin
            program_mode_reg <= pgm_go & ~error_set;
            erase_mode_reg <= erase_go & ~error_set;
            program_verify_mode_reg <= pv_go;
            erase_verify_mode_reg <= ev_go;
            erase_block_enable_reg <= erase_block_enable_next;
            overlay_active_reg <= ram_select;
            nmi_mask_reg <= nmi_mask_next;
            device_reset_reg <= any_reset;
            reg_rdata_reg <= reg_rdata_next;
            flash_rd_data_reg <= flash_rd_data_next;
        end
    end

    assign program_mode = program_mode_reg;
    assign erase_mode = erase_mode_reg;
    assign program_verify_mode = program_verify_mode_reg;
    assign erase_verify_mode = erase_verify_mode_reg;
    assign erase_block_enable = erase_block_enable_reg;
    assign overlay_active = overlay_active_reg;
    assign nmi_mask = nmi_mask_reg;
    assign device_reset = device_reset_reg;
    assign reg_rdata = reg_rdata_reg;
    assign flash_rd_data = flash_rd_data_reg;

    // Checks on the protection behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_pin_low_clears: assert property (ce && !flash_write_enable_pin |=>
        flash_control_reg == CTRL_RESET && erase_block_select_reg == BLK_ZERO
        && !program_mode && !erase_mode && !program_verify_mode)
        else $error("write-enable pin low did not clear and protect");

    a_standby_init: assert property (ce && (sw_standby || hw_standby || watchdog_reset)
        |=> flash_control_reg == CTRL_RESET && erase_block_select_reg == BLK_ZERO)
        else $error("reset or standby did not initialise registers");

    a_error_sets_flag: assert property (ce && error_detect
        && (program_mode || erase_mode) |=> flash_error_flag_reg && !program_mode && !erase_mode)
        else $error("error during operation not latched or not aborted");

    a_error_keeps_ctrl: assert property (ce && error_set && !init_regs && !wr_ctrl |=>
        flash_control_reg == $past(flash_control_reg))
        else $error("control register lost on entering error protection");

    a_error_blocks_entry: assert property (ce && flash_error_flag_reg |=>
        !program_mode && !erase_mode)
        else $error("program or erase entered with error flag set");

    a_verify_in_error: assert property (ce && flash_error_flag_reg && pv_go |=>
        program_verify_mode)
        else $error("program verify refused under error protection");

    a_error_sticky: assert property (flash_error_flag_reg && !(ce && error_clear) |=>
        flash_error_flag_reg)
        else $error("error flag cleared by an event that may not clear it");

    a_overlay_protects: assert property (ce && ram_select |=>
        !program_mode && !erase_mode && erase_block_enable == BLK_ZERO)
        else $error("program or erase allowed with overlay selected");

    a_zero_blocks: assert property (ce && !blocks_chosen |=> !erase_mode
        && erase_block_enable == BLK_ZERO)
        else $error("erase allowed with no block selected");

    a_nmi_masked: assert property (ce && (busy || flash_error_flag_reg || boot_hold)
        |=> nmi_mask)
        else $error("NMI not masked during operation, error or early boot");

    a_undef_read: assert property (ce && busy |=> flash_rd_data == UNDEF_READ)
        else $error("flash data passed through during program or erase");

    // Further checks on pin protection, entry conditions, NMI release and resets.
    a_overlay_cleared: assert property (ce && hw_protect |=>
        ram_overlay_control_reg == RAMC_RESET)
        else $error("RAM overlay kept while write-enable pin low");

    a_hw_no_erase: assert property (ce && hw_protect |=>
        !erase_mode && erase_block_enable == BLK_ZERO)
        else $error("block erase enabled under hardware protection");

    a_ev_in_error: assert property (ce && flash_error_flag_reg && ev_go |=>
        erase_verify_mode)
        else $error("erase verify refused under error protection");

    a_pgm_free: assert property (ce && sw_enable_ok && flash_control_reg[CTRL_PGM]
        && flash_control_reg[CTRL_PSU] && !flash_error_flag_reg && !ram_select && !error_set
        |=> program_mode)
        else $error("program entry refused by the block selection");

    a_nmi_released: assert property (ce && !busy && !flash_error_flag_reg && !emu_hold
        && !boot_hold |=> !nmi_mask)
        else $error("NMI still masked with no program, erase, error or boot hold");

    a_wdt_resets: assert property (ce && watchdog_reset |=> device_reset)
        else $error("watchdog reset not passed to the device reset");

    a_pin_reset_clears: assert property (ce && rf.pin_reset && !error_set |=>
        flash_control_reg == CTRL_RESET && !flash_error_flag_reg && device_reset)
        else $error("qualified pin reset did not initialise the core");

    c_program_mode: cover property (program_mode);
    c_erase_mode: cover property (erase_mode && erase_block_enable != BLK_ZERO);
    c_error_verify: cover property (flash_error_flag_reg && program_verify_mode);
    c_boot_release: cover property (boot_mode && boot_branch_ram ##2 !nmi_mask);

endmodule // flash_protect

/* design/reset_filter_if.sv */
// Interface between the protection core and its external reset pin filter.
`timescale 1ns/1ns
interface reset_filter_if;
    logic ce;
    logic external_reset_pin_n;
    logic pin_reset;

    modport filter (
        input ce,
        input external_reset_pin_n,
        output pin_reset
    );

    modport core (
        output ce,
        output external_reset_pin_n,
        input pin_reset
    );
endinterface // reset_filter_if

/* design/reset_pin_filter.sv */
// Qualifier that accepts an external reset pin low only after a minimum hold.
`timescale 1ns/1ns
module reset_pin_filter
    import flash_prot_pkg::*;
#(
    parameter int HOLD = RESET_HOLD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    reset_filter_if.filter rf
);
    localparam int CW = $clog2(HOLD + 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_LAST = CW'(HOLD - 1);

    // A zero hold would let any glitch on the pin reset the core.
    if (HOLD < 1) begin : g_bad_hold
        $error("reset_pin_filter: HOLD must be at least one cycle");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic pin_reset_reg;
    logic pin_reset_next;

    // Short glitches restart the count, so only a held low resets the core.
    assign cnt_next = rf.external_reset_pin_n ? CNT_ZERO :
                      (cnt_reg == CNT_LAST) ? cnt_reg : cnt_reg + 1'b1;
    assign pin_reset_next = ~rf.external_reset_pin_n & (cnt_reg == CNT_LAST);
    assign rf.pin_reset = pin_reset_reg;

    // Counter and qualified reset level.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= CNT_ZERO;
            pin_reset_reg <= 1'b0;
        end else if (rf.ce) begin
            cnt_reg <= cnt_next;
            pin_reset_reg <= pin_reset_next;
        end
    end

    a_pin_reset_hold: assert property (@(posedge clk_sys) disable iff (rst)
        rf.pin_reset |-> cnt_reg == CNT_LAST)
        else $error("pin reset taken before the hold count completed");

    a_pin_glitch_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        rf.ce && rf.external_reset_pin_n |=> !rf.pin_reset)
        else $error("pin reset asserted after the pin went high");

    c_pin_reset_seen: cover property (@(posedge clk_sys) disable iff (rst) rf.pin_reset);

endmodule // reset_pin_filter

/* tb/cpu_sw_model.sv */
// Behavioural model of the CPU software that reaches the protection registers.
`timescale 1ns/1ns
module cpu_sw_model (
    input wire logic clk_sys,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // The bus idles with both strobes low; no interrupt or bus-release request exists here.
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write; the data lines then carry the inverse so stale data is never reused.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // One-cycle read; the answer is picked up by the bench one cycle later.
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask

    // Erase start: blocks first, then setup, erase and enable bits together.
    task automatic erase_on(input logic [7:0] blocks);
        wr(4'h4, blocks);
        wr(4'h0, 8'h62);
    endtask

    // Erase end: erase bits cleared first, then the block selection goes back to zero.
    task automatic erase_off();
        wr(4'h0, 8'h40);
        wr(4'h4, 8'h00);
    endtask
endmodule // cpu_sw_model

/* tb/test_flash_protect.sv */
// Self-checking testbench for the flash program and erase protection core.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_flash_protect;
    import flash_prot_pkg::*;
    logic clk_sys, rst, flash_write_enable_pin, external_reset_pin_n, boot_mode;
    logic [4:0] evt;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, flash_array_data, flash_rd_data, exp_v;
    logic reg_wr, reg_rd, program_mode, erase_mode, pv_mode, ev_mode;
    logic overlay_active, nmi_mask, device_reset, rd_seen, ce;
    logic [7:0] erase_block_enable;
    logic [31:0] rnd;
    logic [7:0] exp_q[$];
    int errors = 0;
    int n_compared = 0;

    flash_protect #(.NUM_BLOCKS(8)) i_flash_protect (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .flash_write_enable_pin(flash_write_enable_pin),
        .external_reset_pin_n(external_reset_pin_n), .watchdog_reset(evt[0]),
        .sw_standby(evt[1]), .hw_standby(evt[2]), .error_detect(evt[3]),
        .boot_mode(boot_mode), .boot_branch_ram(evt[4]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_array_data(flash_array_data), .flash_rd_data(flash_rd_data),
        .program_mode(program_mode), .erase_mode(erase_mode),
        .program_verify_mode(pv_mode), .erase_verify_mode(ev_mode),
        .erase_block_enable(erase_block_enable), .overlay_active(overlay_active),
        .nmi_mask(nmi_mask), .device_reset(device_reset));

    cpu_sw_model i_cpu_sw_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    // Free-running 10 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // The expectation is queued before the strobe so the watcher always finds it.
    task automatic rd(input logic [3:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        i_cpu_sw_model.rd(a);
    endtask

    task automatic pulse(input int k);
        @(posedge clk_sys);
        evt[k] <= 1'b1;
        @(posedge clk_sys);
        evt[k] <= 1'b0;
    endtask

    task automatic pin_low(input int n);
        @(posedge clk_sys);
        external_reset_pin_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        external_reset_pin_n <= 1'b1;
    endtask

    // Starts an erase and reports a fault while it runs.
    task automatic make_error();
        i_cpu_sw_model.erase_on(8'h01);
        tick(2);
        pulse(3);
        tick(1);
    endtask

    task automatic test_done();
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read data are sampled at the falling edge, well clear of the update edge.
    always @(negedge clk_sys) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK("reg_rdata", exp_v, reg_rdata)
        end
        rd_seen = reg_rd;
    end

    // A hang anywhere ends the run as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        flash_write_enable_pin = 1'b1;
        external_reset_pin_n = 1'b1;
        boot_mode = 1'b0;
        evt = 5'h00;
        flash_array_data = 8'h00;
        rd_seen = 1'b0;
        rnd = 32'hbf6cb0a5;
        tick(6);
        rst <= 1'b0;
        tick(1);
        // Reset contents, an unmapped address and a random plain storage bit.
        rd(OFS_CTRL, CTRL_RESET);
        rd(OFS_EBS, EBS_RESET);
        rd(OFS_RAMC, RAMC_RESET);
        rd(OFS_STAT, 8'h00);
        i_cpu_sw_model.wr(4'h2, 8'hff);
        rd(4'h2, 8'h00);
        rnd = lfsr(rnd);
        i_cpu_sw_model.wr(OFS_CTRL, {rnd[0], 7'h00});
        rd(OFS_CTRL, {rnd[0], 7'h00});
        // A write while the clock enable is low must be lost.
        @(posedge clk_sys);
        ce <= 1'b0;
        i_cpu_sw_model.wr(OFS_CTRL, 8'h51);
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(OFS_CTRL, {rnd[0], 7'h00});
        // Program entry with no block selected; flash reads turn undefined.
        i_cpu_sw_model.wr(OFS_CTRL, 8'h51);
        tick(1);
        rd(OFS_STAT, 8'h21);
        @(negedge clk_sys);
        `CHK("flash_rd_data", UNDEF_READ, flash_rd_data)
        `CHK("program_mode", 1'b1, program_mode)
        `CHK("nmi_mask", 1'b1, nmi_mask)
        // Erase with an empty selection stays off; reads pass array data again.
        i_cpu_sw_model.wr(OFS_CTRL, 8'h62);
        tick(1);
        rd(OFS_STAT, 8'h00);
        rnd = lfsr(rnd);
        @(posedge clk_sys);
        flash_array_data <= rnd[15:8];
        tick(2);
        @(negedge clk_sys);
        `CHK("flash_rd_data", rnd[15:8], flash_rd_data)
        i_cpu_sw_model.wr(OFS_EBS, 8'h05);
        tick(1);
        rd(OFS_STAT, 8'h22);
        @(negedge clk_sys);
        `CHK("erase_block_enable", 8'h05, erase_block_enable)
        `CHK("erase_mode", 1'b1, erase_mode)
        // A fault mid-erase: flag set, erase aborted, registers kept.
        pulse(3);
        tick(1);
        rd(OFS_STAT, 8'ha0);
        rd(OFS_CTRL, 8'h62);
        rd(OFS_EBS, 8'h05);
        i_cpu_sw_model.wr(OFS_CTRL, 8'h51);
        tick(1);
        rd(OFS_STAT, 8'ha0);
        i_cpu_sw_model.wr(OFS_CTRL, 8'h44);
        tick(1);
        rd(OFS_STAT, 8'ha4);
        @(negedge clk_sys);
        `CHK("pv_mode", 1'b1, pv_mode)
        i_cpu_sw_model.wr(OFS_CTRL, 8'h48);
        tick(1);
        rd(OFS_STAT, 8'ha8);
        @(negedge clk_sys);
        `CHK("ev_mode", 1'b1, ev_mode)
        i_cpu_sw_model.wr(OFS_EBS, 8'h33);
        rd(OFS_EBS, 8'h33);
        pulse(1);
        tick(1);
        rd(OFS_CTRL, 8'h00);
        rd(OFS_EBS, 8'h00);
        rd(OFS_STAT, 8'ha0);
        // A reset pin low for one cycle too few is ignored; a long one clears the fault.
        pin_low(19);
        tick(2);
        rd(OFS_STAT, 8'ha0);
        pin_low(23);
        @(negedge clk_sys);
        `CHK("device_reset", 1'b1, device_reset)
        tick(2);
        rd(OFS_STAT, 8'h00);
        // Watchdog and hardware standby each release the fault and clear the registers.
        for (int k = 0; k < 3; k += 2) begin
            make_error();
            rd(OFS_STAT, 8'ha0);
            pulse(k);
            tick(1);
            rd(OFS_STAT, 8'h00);
            rd(OFS_CTRL, 8'h00);
        end
        // RAM overlay blocks programming but not verify.
        i_cpu_sw_model.wr(OFS_RAMC, 8'h08);
        i_cpu_sw_model.wr(OFS_CTRL, 8'h51);
        tick(1);
        rd(OFS_STAT, 8'h20);
        @(negedge clk_sys);
        `CHK("overlay_active", 1'b1, overlay_active)
        i_cpu_sw_model.wr(OFS_CTRL, 8'h44);
        tick(1);
        rd(OFS_STAT, 8'h04);
        // Write-enable pin low: registers and overlay cleared, writes lost.
        @(posedge clk_sys);
        flash_write_enable_pin <= 1'b0;
        tick(2);
        rd(OFS_STAT, 8'h10);
        rd(OFS_CTRL, 8'h00);
        rd(OFS_RAMC, 8'h00);
        @(negedge clk_sys);
        `CHK("overlay_active", 1'b0, overlay_active)
        i_cpu_sw_model.erase_on(8'hff);
        tick(1);
        rd(OFS_EBS, 8'h00);
        rd(OFS_STAT, 8'h10);
        @(negedge clk_sys);
        `CHK("erase_block_enable", 8'h00, erase_block_enable)
        @(posedge clk_sys);
        flash_write_enable_pin <= 1'b1;
        // Boot mode holds NMI off until the branch into RAM.
        boot_mode <= 1'b1;
        pulse(0);
        tick(2);
        rd(OFS_STAT, 8'h20);
        pulse(4);
        tick(1);
        rd(OFS_STAT, 8'h00);
        i_cpu_sw_model.wr(OFS_CTRL, 8'h51);
        tick(1);
        rd(OFS_STAT, 8'h21);
        i_cpu_sw_model.erase_off();
        tick(3);
        `CHK("exp_q", 0, exp_q.size())
        test_done();
    end
endmodule // test_flash_protect
